// ===== logic/bmc_regs.svh
// Constants for the host bus front end: field positions, reset values and widths.
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH

`define BMC_PORT_WIDTH     8
`define BMC_ADDR_WIDTH     20
`define BMC_BURST_SHIFT    4
`define BMC_ADDR_RESET     20'h00000
`define BMC_PORT_RESET     8'h00
`define BMC_STATE_RESET    3'h1

`endif

// ===== logic/bmc_pkg.sv
// Types shared by the host bus front end modules.
`default_nettype none
package bmc_pkg;

    // Wiring of the two address/data ports.
    typedef enum logic [1:0] {
        BMC_BUS_MUX    = 2'h0,
        BMC_BUS_NONMUX = 2'h1,
        BMC_BUS_PAGE   = 2'h2,
        BMC_BUS_BURST  = 2'h3
    } bmc_bus_mode_type;

    typedef enum logic {
        BMC_C0_WRITE_STROBE = 1'h0,
        BMC_C0_DIRECTION    = 1'h1
    } bmc_ctl0_mode_type;

    typedef enum logic [1:0] {
        BMC_C1_READ_STROBE = 2'h0,
        BMC_C1_PHASE_CLOCK = 2'h1,
        BMC_C1_DATA_STROBE = 2'h2,
        BMC_C1_FETCH_READ  = 2'h3
    } bmc_ctl1_mode_type;

    typedef enum logic {
        BMC_C2_FETCH   = 1'h0,
        BMC_C2_GENERIC = 1'h1
    } bmc_ctl2_mode_type;

    typedef enum logic [2:0] {
        BMC_STATE_IDLE = 3'h1,
        BMC_STATE_ADDR = 3'h2,
        BMC_STATE_DATA = 3'h4
    } bmc_state_type;

    typedef struct packed {
        bmc_bus_mode_type  bus;
        bmc_ctl0_mode_type ctl0;
        bmc_ctl1_mode_type ctl1;
        bmc_ctl2_mode_type ctl2;
    } bmc_cfg_type;

    // Control terms offered to the decode and logic arrays.
    typedef struct packed {
        logic       read;
        logic       write;
        logic       code;
        logic       phase;
        logic       generic;
        logic [2:0] raw;
    } bmc_ctrl_type;

endpackage : bmc_pkg
`default_nettype wire

// ===== logic/bmc_ctl_decode.sv
// Interprets the three control inputs according to the configured host type.
`timescale 1ns/1ns
`default_nettype none
module bmc_ctl_decode
    import bmc_pkg::*;
(
    // Configuration.
    input  wire bmc_cfg_type  cfg_in,
    // Control pins.
    input  wire logic         control_input_zero_in,
    input  wire logic         control_input_one_in,
    input  wire logic         control_input_two_in,
    // Decoded terms.
    output var bmc_ctrl_type  ctrl_out
);

    wire dir_mode     = (cfg_in.ctl0 == BMC_C0_DIRECTION);
    wire dir_read     = control_input_zero_in;
    wire write_strobe = ~control_input_zero_in;
    wire phase_clock  = (cfg_in.ctl1 == BMC_C1_PHASE_CLOCK) & control_input_one_in;
    wire data_strobe_n = control_input_one_in;
    wire strobe_mode  = (cfg_in.ctl1 == BMC_C1_PHASE_CLOCK) ||
                        (cfg_in.ctl1 == BMC_C1_DATA_STROBE);
    wire cycle_qual   = (cfg_in.ctl1 == BMC_C1_PHASE_CLOCK) ? phase_clock : ~data_strobe_n;
    wire read_low     = ~control_input_one_in;
    wire fetch_mode   = (cfg_in.ctl2 == BMC_C2_FETCH);
    wire code_cycle   = fetch_mode & ~control_input_two_in;

    // A direction line only means something while the cycle qualifier is on.
    wire read_dir     = dir_mode & strobe_mode & cycle_qual & dir_read;
    wire write_dir    = dir_mode & strobe_mode & cycle_qual & ~dir_read;
    wire read_plain   = ~strobe_mode & read_low;
    wire write_plain  = ~dir_mode & write_strobe;

    assign ctrl_out.read    = read_dir | read_plain | code_cycle;
    assign ctrl_out.write   = write_dir | write_plain;
    assign ctrl_out.code    = code_cycle;
    assign ctrl_out.phase   = strobe_mode & cycle_qual;
    assign ctrl_out.generic = ~fetch_mode & control_input_two_in;
    assign ctrl_out.raw     = {control_input_two_in, control_input_one_in,
                               control_input_zero_in};

endmodule : bmc_ctl_decode
`default_nettype wire

// ===== logic/bmc_front_end.sv
// Host bus front end: address latch, control decode and read data drive.
`timescale 1ns/1ns
`default_nettype none
`include "bmc_regs.svh"
module bmc_front_end
    import bmc_pkg::*;
#(
    parameter int PORT_W = `BMC_PORT_WIDTH,
    parameter int ADDR_W = `BMC_ADDR_WIDTH
) (
    // Clock and reset.
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    // Configuration.
    input  wire bmc_cfg_type          cfg_in,
    // Lower address/data port.
    input  wire logic [PORT_W-1:0]    lower_addr_data_port_in,
    output logic      [PORT_W-1:0]    lower_addr_data_port_out,
    output logic                      lower_addr_data_port_oe_out,
    // Upper address/data port.
    input  wire logic [PORT_W-1:0]    upper_addr_data_port_in,
    output logic      [PORT_W-1:0]    upper_addr_data_port_out,
    output logic                      upper_addr_data_port_oe_out,
    // Control inputs.
    input  wire logic                 address_strobe_in,
    input  wire logic                 control_input_zero_in,
    input  wire logic                 control_input_one_in,
    input  wire logic                 control_input_two_in,
    // Internal block side.
    input  wire logic                 block_select_in,
    input  wire logic [2*PORT_W-1:0]  read_data_in,
    // Decode array side.
    output logic      [ADDR_W-1:0]    pld_addr_out,
    output var bmc_ctrl_type          pld_ctrl_out,
    output logic                      bus_cycle_out
);

    bmc_ctrl_type         ctrl_dec;
    bmc_state_type        state_reg;
    bmc_state_type        state_next;
    logic [2*PORT_W-1:0]  addr_latch_reg;
    logic [ADDR_W-1:0]    pld_addr_next;
    logic [2*PORT_W-1:0]  drive_data_next;

    bmc_ctl_decode u_ctl_decode (
        .cfg_in                (cfg_in),
        .control_input_zero_in (control_input_zero_in),
        .control_input_one_in  (control_input_one_in),
        .control_input_two_in  (control_input_two_in),
        .ctrl_out              (ctrl_dec)
    );

    wire [2*PORT_W-1:0] port_word = {upper_addr_data_port_in, lower_addr_data_port_in};
    wire mode_nonmux = (cfg_in.bus == BMC_BUS_NONMUX);
    wire mode_page   = (cfg_in.bus == BMC_BUS_PAGE);
    wire mode_burst  = (cfg_in.bus == BMC_BUS_BURST);
    wire mode_mux    = (cfg_in.bus == BMC_BUS_MUX);

    // The data lanes depend on which port carries multiplexed lines.
    wire lane_low  = mode_mux | mode_burst;
    wire lane_high = mode_page | mode_burst;

    // Drive is held off while the address is still on the wires and on any write.
    wire read_go   = ctrl_dec.read & block_select_in & ~ctrl_dec.write &
                     ~address_strobe_in;

    // A non-multiplexed host keeps the address valid, so it passes straight through.
    wire [2*PORT_W-1:0] addr_word = mode_nonmux ? port_word : addr_latch_reg;

    // Page mode puts the low data byte on the upper lanes.
    wire [PORT_W-1:0] high_byte = mode_page ? read_data_in[PORT_W-1:0]
                                            : read_data_in[2*PORT_W-1:PORT_W];

    always_comb begin
        pld_addr_next = '0;
        if (mode_burst) begin
            pld_addr_next[ADDR_W-1:`BMC_BURST_SHIFT] =
                addr_word[ADDR_W-`BMC_BURST_SHIFT-1:0];
        end else begin
            pld_addr_next[2*PORT_W-1:0] = addr_word;
        end
    end

    always_comb begin
        drive_data_next = {high_byte, read_data_in[PORT_W-1:0]};
    end

    always_comb begin
        case (state_reg)
            BMC_STATE_IDLE: begin
                state_next = address_strobe_in ? BMC_STATE_ADDR : BMC_STATE_IDLE;
            end
            BMC_STATE_ADDR: begin
                state_next = address_strobe_in ? BMC_STATE_ADDR :
                             (ctrl_dec.read | ctrl_dec.write) ? BMC_STATE_DATA : BMC_STATE_IDLE;
            end
            BMC_STATE_DATA: begin
                state_next = address_strobe_in ? BMC_STATE_ADDR :
                             (ctrl_dec.read | ctrl_dec.write) ? BMC_STATE_DATA : BMC_STATE_IDLE;
            end
            default: begin
                state_next = BMC_STATE_IDLE;
            end
        endcase
    end

    // Reset returns latch, port drivers and array terms to their idle values.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_latch_reg <= {`BMC_PORT_RESET, `BMC_PORT_RESET};
        end else if (address_strobe_in) begin
            addr_latch_reg <= port_word;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= BMC_STATE_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pld_addr_out <= `BMC_ADDR_RESET;
            pld_ctrl_out <= '0;
        end else begin
            pld_addr_out <= pld_addr_next;
            pld_ctrl_out <= ctrl_dec;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lower_addr_data_port_oe_out <= 1'b0;
            upper_addr_data_port_oe_out <= 1'b0;
            lower_addr_data_port_out    <= `BMC_PORT_RESET;
            upper_addr_data_port_out    <= `BMC_PORT_RESET;
        end else begin
            lower_addr_data_port_oe_out <= read_go & lane_low;
            upper_addr_data_port_oe_out <= read_go & lane_high;
            lower_addr_data_port_out    <= drive_data_next[PORT_W-1:0];
            upper_addr_data_port_out    <= drive_data_next[2*PORT_W-1:PORT_W];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_cycle_out <= 1'b0;
        end else begin
            bus_cycle_out <= (state_next == BMC_STATE_DATA);
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    property p_latch_capture;
        address_strobe_in |=> addr_latch_reg == $past(port_word);
    endproperty
    a_latch_capture: assert property (p_latch_capture)
        else $error("Address latch missed the strobed address.");

    property p_latch_hold;
        !address_strobe_in |=> $stable(addr_latch_reg);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Address latch changed without a strobe.");

    property p_drive_cause;
        (lower_addr_data_port_oe_out || upper_addr_data_port_oe_out) |->
            $past(ctrl_dec.read && block_select_in);
    endproperty
    a_drive_cause: assert property (p_drive_cause)
        else $error("Port driven without a selected read.");

    property p_drive_data;
        lower_addr_data_port_oe_out && !$past(mode_page) |->
            lower_addr_data_port_out == $past(read_data_in[PORT_W-1:0]);
    endproperty
    a_drive_data: assert property (p_drive_data)
        else $error("Driven byte differs from the read data.");

    property p_no_contend;
        (ctrl_dec.write || address_strobe_in) |=>
            !lower_addr_data_port_oe_out && !upper_addr_data_port_oe_out;
    endproperty
    a_no_contend: assert property (p_no_contend)
        else $error("Port driven during a write or address phase.");

    property p_route_nonmux;
        mode_nonmux |=> pld_addr_out[2*PORT_W-1:0] == $past(port_word);
    endproperty
    a_route_nonmux: assert property (p_route_nonmux)
        else $error("Non-multiplexed address not passed to the arrays.");

    property p_write_strobe;
        cfg_in.ctl0 == BMC_C0_WRITE_STROBE && !control_input_zero_in |=>
            pld_ctrl_out.write;
    endproperty
    a_write_strobe: assert property (p_write_strobe)
        else $error("Low write strobe not seen as a write.");

    property p_direction;
        cfg_in.ctl0 == BMC_C0_DIRECTION && cfg_in.ctl1 == BMC_C1_PHASE_CLOCK &&
            control_input_one_in |=>
            pld_ctrl_out.read == ($past(control_input_zero_in) || pld_ctrl_out.code) &&
            pld_ctrl_out.write == !$past(control_input_zero_in);
    endproperty
    a_direction: assert property (p_direction)
        else $error("Direction level misread.");

    property p_code_cycle;
        cfg_in.ctl2 == BMC_C2_FETCH && !control_input_two_in |=>
            pld_ctrl_out.code && pld_ctrl_out.read;
    endproperty
    a_code_cycle: assert property (p_code_cycle)
        else $error("Fetch strobe not seen as a code read.");

    property p_generic;
        cfg_in.ctl2 == BMC_C2_GENERIC |=>
            pld_ctrl_out.generic == $past(control_input_two_in) && !pld_ctrl_out.code;
    endproperty
    a_generic: assert property (p_generic)
        else $error("Generic input not passed to the arrays.");

    c_mux_read: cover property (address_strobe_in ##1 !address_strobe_in ##1
                                lower_addr_data_port_oe_out);
    c_burst_read: cover property (lower_addr_data_port_oe_out && upper_addr_data_port_oe_out);
    c_write_cycle: cover property (state_reg == BMC_STATE_DATA && pld_ctrl_out.write);

endmodule : bmc_front_end
`default_nettype wire

// ===== sim/bmc_host_model.sv
// Host microcontroller model that drives the address/data ports and control pins.
`timescale 1ns/1ns
`default_nettype none
module bmc_host_model
    import bmc_pkg::*;
(
    // Clock and configuration.
    input  wire logic        clk_in,
    input  wire bmc_cfg_type cfg_in,
    // Device drive of both ports.
    input  wire logic [7:0]  lower_dev_in,
    input  wire logic        lower_oe_in,
    input  wire logic [7:0]  upper_dev_in,
    input  wire logic        upper_oe_in,
    // Resolved pin levels and control pins.
    output logic      [7:0]  lower_pin_out,
    output logic      [7:0]  upper_pin_out,
    output logic             address_strobe_out,
    output logic             control_input_zero_out,
    output logic             control_input_one_out,
    output logic             control_input_two_out
);
    logic [15:0] host_word;

    // The pins show the device where it drives, otherwise the host level.
    assign lower_pin_out = lower_oe_in ? lower_dev_in : host_word[7:0];
    assign upper_pin_out = upper_oe_in ? upper_dev_in : host_word[15:8];

    initial begin
        host_word              = 16'h0000;
        address_strobe_out     = 1'b0;
        control_input_zero_out = 1'b1;
        control_input_one_out  = 1'b1;
        control_input_two_out  = 1'b1;
    end

    // The phase clock idles low, every strobe idles high.
    task automatic set_idle();
        control_input_zero_out = 1'b1;
        control_input_one_out  = (cfg_in.ctl1 != BMC_C1_PHASE_CLOCK);
        control_input_two_out  = 1'b1;
    endtask : set_idle

    // Strobe phase, then data phase; returns in the cycle that shows the answer.
    task automatic host_cycle(input logic [15:0] addr, input logic rd, input logic fetch,
                              input logic hold);
        @(negedge clk_in);
        address_strobe_out = 1'b1;
        host_word          = addr;
        @(negedge clk_in);
        address_strobe_out = 1'b0;
        // Released lines show the inverse, so a stale address cannot pass by luck.
        if (!hold) host_word = ~addr;
        if (fetch) begin
            control_input_two_out = 1'b0;
        end else if (rd) begin
            control_input_zero_out = 1'b1;
            control_input_one_out  = (cfg_in.ctl1 == BMC_C1_PHASE_CLOCK);
        end else begin
            control_input_zero_out = 1'b0;
            if (cfg_in.ctl0 == BMC_C0_DIRECTION)
                control_input_one_out = (cfg_in.ctl1 == BMC_C1_PHASE_CLOCK);
        end
        @(negedge clk_in);
        set_idle();
    endtask : host_cycle
endmodule : bmc_host_model
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking testbench for the host bus front end.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import bmc_pkg::*;

    localparam bmc_cfg_type CFG_MUX = '{BMC_BUS_MUX, BMC_C0_WRITE_STROBE,
                                        BMC_C1_READ_STROBE, BMC_C2_GENERIC};
    logic         clk_in;
    logic         reset_n_in;
    logic         block_select_in;
    bmc_cfg_type  cfg_in;
    logic [15:0]  read_data_in;
    logic [7:0]   lo_pin;
    logic [7:0]   up_pin;
    logic [7:0]   lo_out;
    logic [7:0]   up_out;
    logic         lo_oe;
    logic         up_oe;
    logic         strobe;
    logic         c0;
    logic         c1;
    logic         c2;
    logic [19:0]  pld_addr;
    bmc_ctrl_type ctrl;
    logic         bus_cycle;
    int           fails;
    int           num_checks;

    bmc_front_end bmc_front_end_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .cfg_in(cfg_in),
        .lower_addr_data_port_in(lo_pin), .lower_addr_data_port_out(lo_out),
        .lower_addr_data_port_oe_out(lo_oe), .upper_addr_data_port_in(up_pin),
        .upper_addr_data_port_out(up_out), .upper_addr_data_port_oe_out(up_oe),
        .address_strobe_in(strobe), .control_input_zero_in(c0), .control_input_one_in(c1),
        .control_input_two_in(c2), .block_select_in(block_select_in),
        .read_data_in(read_data_in), .pld_addr_out(pld_addr), .pld_ctrl_out(ctrl),
        .bus_cycle_out(bus_cycle));

    bmc_host_model bmc_host_model_i (.clk_in(clk_in), .cfg_in(cfg_in), .lower_dev_in(lo_out),
        .lower_oe_in(lo_oe), .upper_dev_in(up_out), .upper_oe_in(up_oe),
        .lower_pin_out(lo_pin), .upper_pin_out(up_pin), .address_strobe_out(strobe),
        .control_input_zero_out(c0), .control_input_one_out(c1), .control_input_two_out(c2));

    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic check(input logic [19:0] got, input logic [19:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    // Sets up the configuration, then runs one host bus cycle.
    task automatic go(input bmc_cfg_type c, input logic sel, input logic [15:0] a,
                      input logic rd, input logic fe, input logic hd);
        @(negedge clk_in);
        cfg_in          = c;
        block_select_in = sel;
        #1;
        bmc_host_model_i.set_idle();
        bmc_host_model_i.host_cycle(a, rd, fe, hd);
    endtask : go

    task automatic t_mux_read();
        read_data_in = 16'h5aa5;
        go(CFG_MUX, 1'b1, 16'h12c3, 1'b1, 1'b0, 1'b0);
        check(pld_addr, 20'h012c3, "mux address");
        check(20'(lo_oe), 20'h1, "lower drive");
        check(20'(lo_out), 20'h000a5, "lower data");
        check(20'(up_oe), 20'h0, "upper idle");
        check(20'(ctrl.read), 20'h1, "read term");
        check(20'(bus_cycle), 20'h1, "data phase");
        // Back to back with nothing selected must stay off the bus.
        block_select_in = 1'b0;
        bmc_host_model_i.host_cycle(16'hffff, 1'b1, 1'b0, 1'b0);
        check(20'(lo_oe), 20'h0, "unselected drive");
        check(pld_addr, 20'h0ffff, "second address");
    endtask : t_mux_read

    task automatic t_write();
        go(CFG_MUX, 1'b1, 16'h0042, 1'b0, 1'b0, 1'b0);
        check(20'(ctrl.write), 20'h1, "write term");
        check(20'({lo_oe, up_oe}), 20'h0, "write drive");
        check(20'(ctrl.raw), 20'h6, "raw terms");
    endtask : t_write

    task automatic t_direction();
        bmc_cfg_type c;
        c      = CFG_MUX;
        c.ctl0 = BMC_C0_DIRECTION;
        c.ctl1 = BMC_C1_DATA_STROBE;
        go(c, 1'b1, 16'h3344, 1'b1, 1'b0, 1'b0);
        check(20'({ctrl.read, ctrl.write, lo_oe}), 20'h5, "direction read");
        go(c, 1'b1, 16'h3345, 1'b0, 1'b0, 1'b0);
        check(20'({ctrl.read, ctrl.write, lo_oe}), 20'h2, "direction write");
        c.ctl1 = BMC_C1_PHASE_CLOCK;
        go(c, 1'b1, 16'h7001, 1'b1, 1'b0, 1'b0);
        check(20'({ctrl.read, ctrl.phase}), 20'h3, "phase read");
    endtask : t_direction

    task automatic t_fetch();
        bmc_cfg_type c;
        c      = CFG_MUX;
        c.bus  = BMC_BUS_NONMUX;
        c.ctl1 = BMC_C1_FETCH_READ;
        go(c, 1'b1, 16'habcd, 1'b1, 1'b0, 1'b1);
        check(20'(ctrl.read), 20'h1, "fetch as read");
        check(pld_addr, 20'h0abcd, "nonmux address");
        check(20'({lo_oe, up_oe}), 20'h0, "nonmux drive");
        c      = CFG_MUX;
        c.ctl2 = BMC_C2_FETCH;
        go(c, 1'b0, 16'h0100, 1'b0, 1'b1, 1'b0);
        check(20'({ctrl.code, ctrl.read}), 20'h3, "code fetch");
        go(CFG_MUX, 1'b0, 16'h0101, 1'b0, 1'b1, 1'b0);
        check(20'({ctrl.code, ctrl.generic, ctrl.raw[2]}), 20'h0, "generic input");
    endtask : t_fetch

    task automatic t_lanes();
        bmc_cfg_type c;
        c            = CFG_MUX;
        c.bus        = BMC_BUS_PAGE;
        read_data_in = 16'hc63d;
        go(c, 1'b1, 16'h8e21, 1'b1, 1'b0, 1'b0);
        check(pld_addr, 20'h08e21, "page address");
        check(20'({lo_oe, up_oe, up_out}), 20'h13d, "page lane");
        c.bus = BMC_BUS_BURST;
        go(c, 1'b1, 16'h9e71, 1'b1, 1'b0, 1'b0);
        check(pld_addr, 20'h9e710, "burst address");
        check(20'({lo_oe, up_oe, up_out, lo_out}), 20'h3c63d, "burst lanes");
    endtask : t_lanes

    task automatic t_reset();
        go(CFG_MUX, 1'b1, 16'h4321, 1'b1, 1'b0, 1'b0);
        reset_n_in = 1'b0;
        #1;
        check(20'({lo_oe, up_oe}), 20'h0, "reset drive");
        check(pld_addr, 20'h0, "reset address");
        check(20'({ctrl, bus_cycle}), 20'h0, "reset terms");
        @(negedge clk_in);
        reset_n_in = 1'b1;
    endtask : t_reset

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    initial begin
        #40000;
        fails++;
        test_done();
    end

    initial begin
        fails           = 0;
        num_checks      = 0;
        reset_n_in      = 1'b0;
        cfg_in          = CFG_MUX;
        block_select_in = 1'b0;
        read_data_in    = 16'h0000;
        repeat (8) @(negedge clk_in);
        reset_n_in = 1'b1;
        t_mux_read();
        t_write();
        t_direction();
        t_fetch();
        t_lanes();
        t_reset();
        t_mux_read();
        test_done();
    end
endmodule : testbench
`default_nettype wire
